// ---- irq_unit_assertions.sv ----
/*
  Checker on the ports of the nested interrupt unit.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module irq_unit_checker
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Core side.
  input wire logic irq_req,
  input wire logic take_ack,
  input wire logic exit_ack,
  input wire logic ctx_save,
  input wire logic ctx_restore
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ctx_save_a: assert property (take_ack |=> ctx_save)
    else $error("no context save after entry");
  save_cause_a: assert property (ctx_save |-> $past(take_ack))
    else $error("context save without entry");
  ctx_restore_a: assert property (exit_ack |=> ctx_restore)
    else $error("no context restore after exit");
  entry_drop_a: assert property (take_ack |=> !irq_req)
    else $error("request still offered after entry");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
endmodule // irq_unit_checker

// ---- irq_unit_pkg.sv ----
/*
  Holds the shared constants of the nested interrupt unit: node count,
  priority field layout, register offsets, status bit positions and the
  fixed wiring of service request groups onto interrupt nodes.
  Assumes it is compiled before every module that imports it.
*/
package irq_unit_pkg;

  // ****************************************************************
  // Node and priority layout
  // ****************************************************************
  // Number of interrupt nodes.
  localparam int NODE_COUNT = 32;
  // Bits that hold the node number.
  localparam int NODE_BITS = 5;
  // Stored priority bits per node, giving four levels.
  localparam int PRIO_BITS = 2;
  // Width of one priority field in a priority word.
  localparam int PRIO_FIELD = 8;
  // Position of the stored bits in a field, so levels step by 64.
  localparam int PRIO_SHIFT = 6;
  // Priority fields packed into one word.
  localparam int PRIO_PER_WORD = 4;
  // Reset priority level, the most urgent one.
  localparam logic [1:0] PRIO_RESET = 2'h0;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int ADDR_BITS = 8;
  localparam logic [7:0] OFS_ENABLE_SET = 8'h00;
  localparam logic [7:0] OFS_ENABLE_CLR = 8'h04;
  localparam logic [7:0] OFS_PEND_SET = 8'h08;
  localparam logic [7:0] OFS_PEND_CLR = 8'h0c;
  localparam logic [7:0] OFS_ACTIVE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  // Eight priority words from this offset upward.
  localparam logic [7:0] OFS_PRIO_BASE = 8'h20;
  localparam logic [2:0] PRIO_PAGE = 3'h1;

  // ****************************************************************
  // Status bits of the unit's own interrupt
  // ****************************************************************
  localparam int STATUS_BITS = 4;
  localparam int ST_HW_PEND = 0;
  localparam int ST_SW_PEND = 1;
  localparam int ST_ENTRY = 2;
  localparam int ST_EXIT = 3;

  // ****************************************************************
  // Fixed wiring of request groups onto nodes
  // ****************************************************************
  localparam int SYS_BASE = 0;
  localparam int SYS_COUNT = 2;
  localparam int EVT_BASE = 3;
  localparam int EVT_COUNT = 4;
  localparam int SER_BASE = 9;
  localparam int SER_COUNT = 6;
  localparam int CONV_BASE = 15;
  localparam int CONV_COUNT = 2;
  localparam int CAP_BASE = 21;
  localparam int CAP_COUNT = 4;

  // ****************************************************************
  // AXI4-Lite response codes
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- nested_vector_irq_unit.sv ----
/*
  Holds the nested interrupt unit: 32 nodes with pending and active state,
  per-node enable and priority, an AXI4-Lite register slave, the request
  presented to the core with its entry and exit handshake, and a status
  and mask pair driving one level interrupt out.
  Assumes service requests and core signals are on aclk.
*/
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module nested_vector_irq_unit
  import irq_unit_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [ADDR_BITS-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [ADDR_BITS-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Service request pulses from the peripherals.
  input wire logic [SYS_COUNT-1:0] sys_ctrl_req,
  input wire logic [EVT_COUNT-1:0] event_req,
  input wire logic [SER_COUNT-1:0] serial_req,
  input wire logic [CONV_COUNT-1:0] conv_req,
  input wire logic [CAP_COUNT-1:0] capcomp_req,
  // Request offered to the core.
  output logic irq_req,
  output logic [NODE_BITS-1:0] irq_node,
  output logic [PRIO_BITS-1:0] irq_prio,
  // Handler entry and exit from the core.
  input wire logic take_ack,
  input wire logic [NODE_BITS-1:0] take_node,
  input wire logic exit_ack,
  input wire logic [NODE_BITS-1:0] exit_node,
  // Context stacking commands to the core.
  output logic ctx_save,
  output logic ctx_restore,
  // Level interrupt of the unit's own events.
  output logic irq_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Request line per node, reserved nodes tied low.
  logic [NODE_COUNT-1:0] node_req;
  // Node state and per-cycle hardware pend events.
  logic [NODE_COUNT-1:0] pending;
  logic [NODE_COUNT-1:0] active;
  logic [NODE_COUNT-1:0] hw_set;
  // Software pulses per node.
  logic [NODE_COUNT-1:0] sw_set;
  logic [NODE_COUNT-1:0] sw_clr;
  // Core entry and exit decoded per node.
  logic [NODE_COUNT-1:0] take_dec;
  logic [NODE_COUNT-1:0] leave_dec;
  // Per-node enable register.
  logic [NODE_COUNT-1:0] enable;
  // Per-node priority, packed two bits per node.
  logic [NODE_COUNT*PRIO_BITS-1:0] prio_flat;
  // Status and mask of the unit's own interrupt.
  logic [STATUS_BITS-1:0] status;
  logic [STATUS_BITS-1:0] mask;
  logic [STATUS_BITS-1:0] events;
  // Held write address and data.
  logic aw_hold;
  logic w_hold;
  logic [ADDR_BITS-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // Write commits in this cycle, with its byte-masked data.
  logic wr_fire;
  logic [31:0] wr_bits;
  // Read accepted in this cycle.
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_hit;
  // Arbiter results.
  logic pend_found;
  logic [NODE_BITS-1:0] pend_node;
  logic [PRIO_BITS-1:0] pend_level;
  logic run_found;
  logic [PRIO_BITS-1:0] run_level;

  // ****************************************************************
  // Request wiring
  // ****************************************************************
  // fixed node wiring
  // Each group lands on its own nodes; fan-out to other receivers is outside.
  always_comb
  begin
    node_req = '0;
    node_req[SYS_BASE +: SYS_COUNT] = sys_ctrl_req;
    node_req[EVT_BASE +: EVT_COUNT] = event_req;
    node_req[SER_BASE +: SER_COUNT] = serial_req;
    node_req[CONV_BASE +: CONV_COUNT] = conv_req;
    node_req[CAP_BASE +: CAP_COUNT] = capcomp_req;
  end

  // ****************************************************************
  // Nodes
  // ****************************************************************
  // thirty-two nodes
  // One cell, one priority field and one enable per node.
  for (genvar n = 0; n < NODE_COUNT; n++)
  begin : g_node
    // Byte lane and word of this node's priority field.
    localparam int LANE = n % PRIO_PER_WORD;
    localparam logic [ADDR_BITS-1:0] PADDR = ADDR_BITS'(OFS_PRIO_BASE + 4 * (n / 4));

    assign take_dec[n] = take_ack && (take_node == NODE_BITS'(n));
    assign leave_dec[n] = exit_ack && (exit_node == NODE_BITS'(n));

    node_cell u_cell
    (
      .aclk(aclk),
      .aresetn(aresetn),
      .req_in(node_req[n]),
      .sw_set(sw_set[n]),
      .sw_clr(sw_clr[n]),
      .take(take_dec[n]),
      .leave(leave_dec[n]),
      .pending(pending[n]),
      .active(active[n]),
      .hw_set(hw_set[n])
    );

    // priority field write
    // Only the top two bits of the byte are kept, so levels are 0,64,128,192.
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        prio_flat[n*PRIO_BITS +: PRIO_BITS] <= PRIO_RESET;
      else if (wr_fire && aw_addr_q == PADDR && w_strb_q[LANE])
        prio_flat[n*PRIO_BITS +: PRIO_BITS] <=
          w_data_q[LANE*PRIO_FIELD + PRIO_SHIFT +: PRIO_BITS];
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // A write commits once both address and data are held.
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  // Data bits with unstrobed byte lanes masked off.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wr_bits[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : 8'h00;
  end

  assign sw_set = (wr_fire && aw_addr_q == OFS_PEND_SET) ? wr_bits : '0;
  assign sw_clr = (wr_fire && aw_addr_q == OFS_PEND_CLR) ? wr_bits : '0;

  // Enable bits, set and cleared through separate words.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable <= '0;
    else if (wr_fire && aw_addr_q == OFS_ENABLE_SET)
      enable <= enable | wr_bits;
    else if (wr_fire && aw_addr_q == OFS_ENABLE_CLR)
      enable <= enable & ~wr_bits;
  end

  // Mask of the unit's own interrupt.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask <= '0;
    else if (wr_fire && aw_addr_q == OFS_MASK)
      mask <= wr_bits[STATUS_BITS-1:0];
  end

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  // Address and data are taken in either order and held until commit.
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;

  // Holds the write address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_hold <= 1'b0;
  end

  // Holds the write data and strobes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_hold <= 1'b0;
  end

  // Write response; unmapped or read-only words answer with an error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q == OFS_ENABLE_SET || aw_addr_q == OFS_ENABLE_CLR ||
          aw_addr_q == OFS_PEND_SET || aw_addr_q == OFS_PEND_CLR ||
          aw_addr_q == OFS_MASK || aw_addr_q[7:5] == PRIO_PAGE)
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Read multiplexer; priority words show each level in its byte's top bits.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr[7:5] == PRIO_PAGE)
    begin
      for (int b = 0; b < PRIO_PER_WORD; b++)
        rd_word[b*PRIO_FIELD + PRIO_SHIFT +: PRIO_BITS] =
          prio_flat[(int'(s_axi_araddr[4:2]) * PRIO_PER_WORD + b) * PRIO_BITS +: PRIO_BITS];
    end
    else
    begin
      unique case (s_axi_araddr)
        OFS_ENABLE_SET: rd_word = enable;
        OFS_ENABLE_CLR: rd_word = enable;
        OFS_PEND_SET: rd_word = pending;
        OFS_PEND_CLR: rd_word = pending;
        OFS_ACTIVE: rd_word = active;
        OFS_STATUS: rd_word[STATUS_BITS-1:0] = status;
        OFS_MASK: rd_word[STATUS_BITS-1:0] = mask;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Read data register, answered one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************************
  // Own interrupt
  // ****************************************************************
  assign events[ST_HW_PEND] = |hw_set;
  assign events[ST_SW_PEND] = |sw_set;
  assign events[ST_ENTRY] = take_ack;
  assign events[ST_EXIT] = exit_ack;

  // Sticky status; a read clears it, but an event in that cycle survives.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= '0;
    else if (rd_fire && s_axi_araddr == OFS_STATUS)
      status <= events;
    else
      status <= status | events;
  end

  assign irq_out = |(status & mask);

  // ****************************************************************
  // Arbitration and core request
  // ****************************************************************
  // enable gates offering only
  priority_arbiter u_pend_arb
  (
    .cand(pending & enable & ~active),
    .prio_flat(prio_flat),
    .found(pend_found),
    .node(pend_node),
    .level(pend_level)
  );

  // Running level is the most urgent level among active handlers.
  priority_arbiter u_run_arb
  (
    .cand(active),
    .prio_flat(prio_flat),
    .found(run_found),
    .node(),
    .level(run_level)
  );

  // Registers the offered request; only a more urgent level may nest.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req <= 1'b0;
      irq_node <= '0;
      irq_prio <= '0;
    end
    else
    begin
      irq_req <= pend_found && (!run_found || pend_level < run_level) && !take_ack;
      irq_node <= pend_node;
      irq_prio <= pend_level;
    end
  end

  // context stacking commands
  // Entry asks the core to save context, exit to restore it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctx_save <= 1'b0;
      ctx_restore <= 1'b0;
    end
    else
    begin
      ctx_save <= take_ack;
      ctx_restore <= exit_ack;
    end
  end

endmodule // nested_vector_irq_unit

// ---- node_cell.sv ----
/*
  Holds the pending and active state of one interrupt node.
  Assumes the request input comes from logic on the same clock and that
  take and leave come from the core for this node only.
*/
`timescale 1ns/1ns
module node_cell
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Request and software controls.
  input wire logic req_in,
  input wire logic sw_set,
  input wire logic sw_clr,
  // Core handler entry and exit.
  input wire logic take,
  input wire logic leave,
  // State and event.
  output logic pending,
  output logic active,
  output logic hw_set
);

  // Request level of the previous cycle, for edge detection.
  logic req_q;

  // ****************************************************************
  // Request detection
  // ****************************************************************
  // sampled pulse detection
  // A high input pends the node while idle; a rising edge pends it always.
  assign hw_set = req_in & (~active | ~req_q);

  // Samples the request line on every rising clock edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_q <= 1'b0;
    else
      req_q <= req_in;
  end

  // ****************************************************************
  // Pending state
  // ****************************************************************
  // Any set, by hardware or software, wins over a clear in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending <= 1'b0;
    else if (hw_set || sw_set)
      pending <= 1'b1;
    else if (take || sw_clr)
      pending <= 1'b0;
  end

  // ****************************************************************
  // Active state
  // ****************************************************************
  // Entry makes the node active; return makes it inactive again.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active <= 1'b0;
    else if (take)
      active <= 1'b1;
    else if (leave)
      active <= 1'b0;
  end

endmodule // node_cell

// ---- periph_model.sv ----
/*
  Peripheral side: sends one service request pulse on a chosen node.
  Assumes fire is driven on the clock by the bench.
*/
`timescale 1ns/1ns
module periph_model
(
  // Clock and command.
  input wire logic aclk,
  input wire logic fire,
  input wire logic [4:0] node,
  // Request lines.
  output logic [1:0] sys_ctrl_req,
  output logic [3:0] event_req,
  output logic [5:0] serial_req,
  output logic [1:0] conv_req,
  output logic [3:0] capcomp_req
);
  logic [31:0] vec; // One-hot request vector, high one cycle after each cycle fire is high.
  // Pulses last as many cycles as fire is held, one cycle behind it.
  // one cycle pulse
  always_ff @(posedge aclk)
  begin
    vec <= fire ? (32'h1 << node) : 32'h0;
  end
  assign sys_ctrl_req = vec[1:0];
  assign event_req = vec[6:3];
  assign serial_req = vec[14:9];
  assign conv_req = vec[16:15];
  assign capcomp_req = vec[24:21];
endmodule // periph_model

// ---- priority_arbiter.sv ----
/*
  Picks the most urgent node out of a candidate mask; on a tie the lowest
  node number wins. Purely combinational.
  Assumes priorities are packed two bits per node, node 0 lowest.
*/
`timescale 1ns/1ns
module priority_arbiter
  import irq_unit_pkg::*;
#(
  parameter int N = NODE_COUNT
)
(
  // Candidates and their levels.
  input wire logic [N-1:0] cand,
  input wire logic [N*PRIO_BITS-1:0] prio_flat,
  // Winner.
  output logic found,
  output logic [NODE_BITS-1:0] node,
  output logic [PRIO_BITS-1:0] level
);

  // ****************************************************************
  // Search
  // ****************************************************************
  // lowest level, lowest number
  // A strictly lower level replaces the winner, so ties keep the lower node.
  always_comb
  begin
    found = 1'b0;
    node = '0;
    level = '1;
    for (int i = 0; i < N; i++)
    begin
      if (cand[i] && (!found || (prio_flat[i*PRIO_BITS +: PRIO_BITS] < level)))
      begin
        found = 1'b1;
        node = NODE_BITS'(i);
        level = prio_flat[i*PRIO_BITS +: PRIO_BITS];
      end
    end
  end

endmodule // priority_arbiter

// ---- tb.sv ----
/*
  Self-checking bench of the nested interrupt unit.
  Assumes the package, design files, model and checker are compiled first.
*/
`timescale 1ns/1ns
module tb import irq_unit_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sys_ctrl_req, conv_req, irq_prio;
  logic [3:0] event_req, capcomp_req;
  logic [5:0] serial_req;
  logic irq_req, ctx_save, ctx_restore, irq_out;
  logic [NODE_BITS-1:0] irq_node, take_node = 5'h0, exit_node = 5'h0, fire_node = 5'h0;
  logic take_ack = 1'h0, exit_ack = 1'h0, fire = 1'h0;
  logic [31:0] rd; // Last read data.
  logic [1:0] rs; // Last response code.
  int failures = 0, compares = 0;
  typedef struct {logic [4:0] node; logic [31:0] pend;} row_t;
  row_t rows [6] = '{'{5'h01, 32'h2}, '{5'h03, 32'h8}, '{5'h0e, 32'h4000},
    '{5'h10, 32'h1_0000}, '{5'h15, 32'h20_0000}, '{5'h18, 32'h100_0000}};

  always #5 aclk = ~aclk;

  nested_vector_irq_unit u_nested_vector_irq_unit (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_ctrl_req, .event_req,
    .serial_req, .conv_req, .capcomp_req, .irq_req, .irq_node, .irq_prio, .take_ack,
    .take_node, .exit_ack, .exit_node, .ctx_save, .ctx_restore, .irq_out);
  periph_model u_periph_model (.aclk, .fire, .node(fire_node), .sys_ctrl_req, .event_req,
    .serial_req, .conv_req, .capcomp_req);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus write; both channels offered together, held until taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (!s_axi_bvalid)
    begin
      failures++;
      final_report();
    end
  endtask
  // Bus read; data taken at the edge where rvalid is seen.
  task automatic rd_(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 40);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (!s_axi_rvalid)
    begin
      failures++;
      final_report();
    end
  endtask
  // One-cycle entry or exit of a handler, as the core gives it.
  task automatic core(input logic ex, input logic [4:0] n);
    @(posedge aclk);
    take_ack <= !ex;
    exit_ack <= ex;
    take_node <= n;
    exit_node <= n;
    @(posedge aclk);
    take_ack <= 1'h0;
    exit_ack <= 1'h0;
  endtask
  task automatic pulse(input logic [4:0] n);
    @(posedge aclk);
    fire <= 1'h1;
    fire_node <= n;
    @(posedge aclk);
    fire <= 1'h0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd_(OFS_ENABLE_SET);
    chk("enable reset", rd, 32'h0);
    // Rows: each pulse pends its fixed node though disabled.
    foreach (rows[i])
    begin
      pulse(rows[i].node);
      rd_(OFS_PEND_SET);
      chk("pending", rd, rows[i].pend);
      chk("no offer", 32'(irq_req), 32'h0);
      wr(OFS_PEND_CLR, rows[i].pend);
    end
    rd_(OFS_PEND_CLR);
    chk("cleared", rd, 32'h0);
    rd_(8'hfc);
    chk("unmapped", {rd[29:0], rs}, 32'h2);
    wr(OFS_ACTIVE, 32'h1);
    chk("read-only", 32'(rs), 32'(RESP_SLVERR));
    // Tie between two level-0 nodes, then urgency by level.
    wr(OFS_ENABLE_SET, 32'h18);
    wr(OFS_PEND_SET, 32'h18);
    repeat (3) @(posedge aclk);
    chk("tie winner", {irq_req, 26'h0, irq_node}, 32'h8000_0003);
    wr(OFS_PRIO_BASE, 32'hff00_0000);
    repeat (3) @(posedge aclk);
    chk("urgent", {irq_req, 23'h0, irq_prio, 1'h0, irq_node}, 32'h8000_0004);
    rd_(OFS_PRIO_BASE);
    chk("prio field", rd, 32'hc000_0000);
    core(1'h0, 5'h4);
    rd_(OFS_ACTIVE);
    chk("active", rd, 32'h10);
    rd_(OFS_PEND_SET);
    chk("entry pend", rd, 32'h8);
    pulse(5'h4);
    core(1'h1, 5'h4);
    rd_(OFS_PEND_SET);
    chk("repend", rd, 32'h18);
    wr(OFS_PEND_CLR, 32'h10);
    core(1'h0, 5'h3);
    wr(OFS_PEND_SET, 32'h8);
    wr(OFS_PEND_CLR, 32'h8);
    rd_(OFS_ACTIVE);
    chk("active only", rd, 32'h8);
    core(1'h1, 5'h3);
    rd_(OFS_ACTIVE);
    chk("inactive", rd, 32'h0);
    chk("no reoffer", 32'(irq_req), 32'h0);
    // Status events seen only through the mask.
    chk("masked", 32'(irq_out), 32'h0);
    wr(OFS_MASK, 32'hf);
    chk("unmasked", 32'(irq_out), 32'h1);
    rd_(OFS_STATUS);
    chk("status", rd, 32'hf);
    @(posedge aclk);
    chk("read clear", 32'(irq_out), 32'h0);
    // Reset in mid-run drops pending state and enables.
    wr(OFS_PEND_SET, 32'h8);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd_(OFS_PEND_SET);
    chk("reset pend", rd, 32'h0);
    rd_(OFS_ENABLE_SET);
    chk("reset enable", rd, 32'h0);
    final_report();
  end
endmodule // tb

bind nested_vector_irq_unit irq_unit_checker u_irq_unit_checker (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq_req, .take_ack,
  .exit_ack, .ctx_save, .ctx_restore);
